// file: verilog/scan_linker_defs.vh
// Constants for the scan-path linker instruction register and decoder.
// Assumes the TAP controller state arrives as the 4-bit codes below.
`ifndef SCAN_LINKER_DEFS_VH
`define SCAN_LINKER_DEFS_VH

// ----------------------------------------------------------------
// TAP controller state codes
// ----------------------------------------------------------------
`define TAP_TEST_LOGIC_RESET 4'h0
`define TAP_RUN_TEST_IDLE 4'h1
`define TAP_CAPTURE_DR 4'h3
`define TAP_SHIFT_DR 4'h4
`define TAP_UPDATE_DR 4'h8
`define TAP_CAPTURE_IR 4'ha
`define TAP_SHIFT_IR 4'hb
`define TAP_PAUSE_IR 4'hd
`define TAP_UPDATE_IR 4'hf

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define OP_EXTEST 8'h00
`define OP_INTEST 8'h03
`define OP_BYPASS 8'h81
`define OP_SAMPLE 8'h82
`define OP_COUNT_A 8'h88
`define OP_COUNT_B 8'h09
`define OP_CTL_SCAN_A 8'h8e
`define OP_CTL_SCAN_B 8'h0f
`define OP_COUNTER_SCAN 8'hfa
`define OP_COUNTER_READ 8'h7b
`define OP_ID_BUS_SCAN 8'hfc
`define OP_ID_BUS_READ 8'h7d
`define OP_PATH_SELECT_SCAN 8'h7e

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define IR_W 8
`define CTL_W 10
`define CNT_W 8
`define IDB_W 4
`define PSEL_W 4
`define BSR_W 6
`define IR_RESET 8'hff
`define CTL_RESET 10'h000
`define CNT_RESET 8'h00
`define IDB_RESET 4'h0
`define PSEL_RESET 4'h0
`define BSR_RESET 6'h00
`define SYNC_RESET 9'h003 // Test clock and test reset idle high
`define CNT_FULL 8'hff

// ----------------------------------------------------------------
// Status word and control register fields
// ----------------------------------------------------------------
`define STAT_PARITY_BIT 7
`define STAT_COND_BIT 3
`define STAT_ONE_BIT 0
`define CTL_DOWN 9
`define CTL_LATCH_ZERO 8
`define CTL_OUT_HIGH 7
`define CTL_SRC_HI 6
`define CTL_SRC_LO 5
`define CTL_PARITY_MASK 4
`define CTL_TRISTATE 3
`define CTL_OUT_EN 2
`define CTL_IN_HIGH 1

// Boundary cells: id bus in [3:0], condition input 4, condition output 5
`define BSR_COND_IN 4
`define BSR_COND_OUT 5

`endif

// file: verilog/scan_shift_stage.v
// Serial shift register with parallel capture and a shadow latch.
// Assumes one-cycle enables from the caller; shifts LSB toward serial out.
module scan_shift_stage #(
	parameter W = 8,
	parameter [W-1:0] RST = {W{1'b0}}
) (
	input wire clk_i,
	input wire clear_i,
	input wire capture_i,
	input wire shift_i,
	input wire update_i,
	input wire serial_i,
	input wire [W-1:0] capture_val_i,
	output reg [W-1:0] shift_o,
	output reg [W-1:0] latch_o
);

	// ----------------------------------------------------------------
	// Shift path and shadow latch
	// ----------------------------------------------------------------
	// Shadow only moves on update, so a scan in progress never disturbs it
	always @(posedge clk_i) begin
		if (clear_i) begin
			shift_o <= RST;
			latch_o <= RST;
		end else begin
			if (capture_i) begin
				shift_o <= capture_val_i;
			end else if (shift_i) begin
				shift_o <= {serial_i, shift_o[W-1:1]}; // MSB in, LSB out
			end
			if (update_i) begin
				latch_o <= shift_o;
			end
		end
	end

endmodule

// file: verilog/scan_linker_instruction_decode.v
// Instruction register, opcode decoder and data registers of a scan linker.
// Assumes the TAP state arrives from a controller on CLK_I; test pins are
// asynchronous and are sampled here on the 200 MHz clock.
// Summary of operation
// - 8-bit shift register with latched instruction
// - Odd ones count drives parity fault low
// - Parity fault shown on condition output
// - Capture-IR loads parity, condition, fixed one
// - 00 and 03 select boundary, test mode
// - Test mode drives loaded boundary outputs
// - Bypass register captures zero
// - 82 samples boundary in normal mode
// - Count opcodes step counter in Run-Test/Idle
// - Counting resumes from previous value
// - Direction and edge follow control register
// - Control scan captures nothing
// - FA captures live count, update preloads
// - 7B captures prior preload, update preloads
// - FC captures identification bus
// - 7D reads held id bus data, 7E path select
// - One register per opcode, others bypass
// - Sample on rising, change on falling
// - Instruction latch changes only in Update-IR
// - Test reset restores power-up values
`include "scan_linker_defs.vh"

module scan_linker_instruction_decode (
	input wire CLK_I,
	input wire RESETN_I,
	input wire TCK_I,
	input wire TRST_N_I,
	input wire TDI_I,
	input wire SECONDARY_SERIAL_IN_I,
	input wire USE_SECONDARY_I,
	input wire [3:0] TAP_STATE_I,
	input wire CONDITION_INPUT_I,
	input wire [3:0] ID_BUS_I,
	output reg TDO_O,
	output reg TDO_OE_O,
	output reg CONDITION_OUTPUT_O,
	output reg CONDITION_OUTPUT_OE_O,
	output reg OPCODE_PARITY_FAULT_N_O,
	output reg TEST_MODE_O,
	output wire [7:0] ACTIVE_OPCODE_O,
	output wire [9:0] CONTROL_O,
	output wire [3:0] PATH_SELECT_O,
	output reg [7:0] COUNT_O
);

	// Selected data register codes
	localparam [2:0] SEL_BYPASS = 3'h0;
	localparam [2:0] SEL_BOUNDARY = 3'h1;
	localparam [2:0] SEL_CONTROL = 3'h2;
	localparam [2:0] SEL_COUNTER = 3'h3;
	localparam [2:0] SEL_ID_BUS = 3'h4;
	localparam [2:0] SEL_PATH = 3'h5;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	reg [8:0] meta_q;
	reg [8:0] sync_q;
	reg tck_prev_q;
	reg cond_prev_q;
	wire tck_s = sync_q[0];
	wire trst_n_s = sync_q[1];
	wire tdi_s = sync_q[2];
	wire sec_tdi_s = sync_q[3];
	wire cond_s = sync_q[4];
	wire [3:0] idb_s = sync_q[8:5];

	// Two flops per pin; only the second stage feeds logic
	always @(posedge CLK_I) begin
		if (!RESETN_I) begin
			meta_q <= `SYNC_RESET;
			sync_q <= `SYNC_RESET;
			tck_prev_q <= 1'b1; // Matches the idle pin, so no false rise follows reset
			cond_prev_q <= 1'b0;
		end else begin
			meta_q <= {ID_BUS_I, CONDITION_INPUT_I, SECONDARY_SERIAL_IN_I, TDI_I,
				TRST_N_I, TCK_I};
			sync_q <= meta_q;
			tck_prev_q <= tck_s;
			cond_prev_q <= cond_s;
		end
	end

	// Test clock edges become one-cycle enables
	wire tck_rise = tck_s & ~tck_prev_q;
	wire tck_fall = ~tck_s & tck_prev_q;

	// ----------------------------------------------------------------
	// State qualifiers and clear
	// ----------------------------------------------------------------
	wire st_tlr = (TAP_STATE_I == `TAP_TEST_LOGIC_RESET);
	wire st_rti = (TAP_STATE_I == `TAP_RUN_TEST_IDLE);
	wire cap_dr = tck_rise & (TAP_STATE_I == `TAP_CAPTURE_DR);
	wire sh_dr = tck_rise & (TAP_STATE_I == `TAP_SHIFT_DR);
	wire upd_dr = tck_rise & (TAP_STATE_I == `TAP_UPDATE_DR);
	wire cap_ir = tck_rise & (TAP_STATE_I == `TAP_CAPTURE_IR);
	wire sh_ir = tck_rise & (TAP_STATE_I == `TAP_SHIFT_IR);
	wire upd_ir = tck_rise & (TAP_STATE_I == `TAP_UPDATE_IR);
	wire in_shift = (TAP_STATE_I == `TAP_SHIFT_DR) | (TAP_STATE_I == `TAP_SHIFT_IR);

	// Test reset pin, system reset or the reset state all restore power-up values
	wire clear = ~RESETN_I | ~trst_n_s | (tck_rise & st_tlr);

	// Data registers may take the secondary serial input
	wire dr_si = USE_SECONDARY_I ? sec_tdi_s : tdi_s;

	// ----------------------------------------------------------------
	// Instruction register and decode
	// ----------------------------------------------------------------
	wire [7:0] ir_shift;
	wire [7:0] ir_lat;
	wire [9:0] ctl;
	reg parity_n_q;
	reg cond_act;
	reg [2:0] sel;
	wire op_count = (ir_lat == `OP_COUNT_A) | (ir_lat == `OP_COUNT_B);
	wire test_mode = (ir_lat == `OP_EXTEST) | (ir_lat == `OP_INTEST);

	// Condition input active level follows its polarity bit
	always @* begin
		cond_act = ctl[`CTL_IN_HIGH] ? cond_s : ~cond_s;
	end

	// Status word: parity flag, condition level, constant one
	wire [7:0] ir_status = {parity_n_q, 3'b000, cond_act, 2'b00, 1'b1};

	// Latch resets to an all-ones bypass code: even parity, one-bit path
	scan_shift_stage #(.W(`IR_W), .RST(`IR_RESET)) u_ir (
		.clk_i(CLK_I),
		.clear_i(clear),
		.capture_i(cap_ir),
		.shift_i(sh_ir),
		.update_i(upd_ir),
		.serial_i(tdi_s),
		.capture_val_i(ir_status),
		.shift_o(ir_shift),
		.latch_o(ir_lat)
	);

	// Parity of the opcode taken at Update-IR; even count of ones is good
	always @(posedge CLK_I) begin
		if (clear) begin
			parity_n_q <= 1'b1;
		end else if (upd_ir) begin
			parity_n_q <= ~(^ir_shift);
		end
	end

	// Every opcode picks exactly one data register
	always @* begin
		case (ir_lat)
		`OP_EXTEST, `OP_INTEST, `OP_SAMPLE: sel = SEL_BOUNDARY;
		`OP_CTL_SCAN_A, `OP_CTL_SCAN_B: sel = SEL_CONTROL;
		`OP_COUNTER_SCAN, `OP_COUNTER_READ: sel = SEL_COUNTER;
		`OP_ID_BUS_SCAN, `OP_ID_BUS_READ: sel = SEL_ID_BUS;
		`OP_PATH_SELECT_SCAN: sel = SEL_PATH;
		default: sel = SEL_BYPASS;
		endcase
	end

	// ----------------------------------------------------------------
	// Data registers
	// ----------------------------------------------------------------
	reg bypass_q;
	reg [7:0] preload_q;
	wire [5:0] bsr_shift;
	wire [5:0] bsr_lat;
	wire [9:0] ctl_shift;
	wire [7:0] cnt_shift;
	wire [3:0] idb_shift;
	wire [3:0] psel_shift;

	// Bypass captures zero before each shift
	always @(posedge CLK_I) begin
		if (clear) begin
			bypass_q <= 1'b0;
		end else if (cap_dr && sel == SEL_BYPASS) begin
			bypass_q <= 1'b0;
		end else if (sh_dr && sel == SEL_BYPASS) begin
			bypass_q <= dr_si;
		end
	end

	// Boundary cells capture pins in both test and sample modes
	scan_shift_stage #(.W(`BSR_W), .RST(`BSR_RESET)) u_bsr (
		.clk_i(CLK_I),
		.clear_i(clear),
		.capture_i(cap_dr && sel == SEL_BOUNDARY),
		.shift_i(sh_dr && sel == SEL_BOUNDARY),
		.update_i(upd_dr && sel == SEL_BOUNDARY),
		.serial_i(dr_si),
		.capture_val_i({CONDITION_OUTPUT_O, cond_s, idb_s}),
		.shift_o(bsr_shift),
		.latch_o(bsr_lat)
	);

	// Control register has no capture value of its own
	scan_shift_stage #(.W(`CTL_W), .RST(`CTL_RESET)) u_ctl (
		.clk_i(CLK_I),
		.clear_i(clear),
		.capture_i(1'b0),
		.shift_i(sh_dr && sel == SEL_CONTROL),
		.update_i(upd_dr && sel == SEL_CONTROL),
		.serial_i(dr_si),
		.capture_val_i(`CTL_RESET),
		.shift_o(ctl_shift),
		.latch_o(ctl)
	);

	// Counter scan path: live count or prior preload on capture
	scan_shift_stage #(.W(`CNT_W), .RST(`CNT_RESET)) u_cnt (
		.clk_i(CLK_I),
		.clear_i(clear),
		.capture_i(cap_dr && sel == SEL_COUNTER),
		.shift_i(sh_dr && sel == SEL_COUNTER),
		.update_i(1'b0),
		.serial_i(dr_si),
		.capture_val_i((ir_lat == `OP_COUNTER_READ) ? preload_q : COUNT_O),
		.shift_o(cnt_shift),
		.latch_o()
	);

	// Id bus is only sampled under its scan opcode; the read opcode keeps data
	scan_shift_stage #(.W(`IDB_W), .RST(`IDB_RESET)) u_idb (
		.clk_i(CLK_I),
		.clear_i(clear),
		.capture_i(cap_dr && ir_lat == `OP_ID_BUS_SCAN),
		.shift_i(sh_dr && sel == SEL_ID_BUS),
		.update_i(1'b0),
		.serial_i(dr_si),
		.capture_val_i(idb_s),
		.shift_o(idb_shift),
		.latch_o()
	);

	// Path select register, not preloaded on capture
	scan_shift_stage #(.W(`PSEL_W), .RST(`PSEL_RESET)) u_psel (
		.clk_i(CLK_I),
		.clear_i(clear),
		.capture_i(1'b0),
		.shift_i(sh_dr && sel == SEL_PATH),
		.update_i(upd_dr && sel == SEL_PATH),
		.serial_i(dr_si),
		.capture_val_i(`PSEL_RESET),
		.shift_o(psel_shift),
		.latch_o(PATH_SELECT_O)
	);

	// ----------------------------------------------------------------
	// Event counter
	// ----------------------------------------------------------------
	wire down = ctl[`CTL_DOWN];
	wire cond_rise = cond_s & ~cond_prev_q;
	wire cond_fall = ~cond_s & cond_prev_q;
	wire cnt_edge = ctl[`CTL_IN_HIGH] ? cond_rise : cond_fall;
	wire hold_zero = down & ctl[`CTL_LATCH_ZERO] & (COUNT_O == `CNT_RESET);
	wire terminal = down ? (COUNT_O == `CNT_RESET) : (COUNT_O == `CNT_FULL);

	// Counting runs off the condition input, not the test clock, so it
	// needs no test clock edges; entering a count opcode never clears it
	always @(posedge CLK_I) begin
		if (clear) begin
			COUNT_O <= `CNT_RESET;
			preload_q <= `CNT_RESET;
		end else if (upd_dr && sel == SEL_COUNTER) begin
			COUNT_O <= cnt_shift;
			preload_q <= cnt_shift;
		end else if (op_count && st_rti && cnt_edge && !hold_zero) begin
			COUNT_O <= down ? COUNT_O - 8'h01 : COUNT_O + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Falling-edge outputs
	// ----------------------------------------------------------------
	reg dr_lsb;
	reg src_act;
	reg level;

	// Serial output picks the LSB of the register in the path
	always @* begin
		case (sel)
		SEL_BOUNDARY: dr_lsb = bsr_shift[0];
		SEL_CONTROL: dr_lsb = ctl_shift[0];
		SEL_COUNTER: dr_lsb = cnt_shift[0];
		SEL_ID_BUS: dr_lsb = idb_shift[0];
		SEL_PATH: dr_lsb = psel_shift[0];
		default: dr_lsb = bypass_q;
		endcase
	end

	// Condition output source and polarity from the control register
	always @* begin
		case (ctl[`CTL_SRC_HI:`CTL_SRC_LO])
		2'b01: src_act = ~parity_n_q & ~ctl[`CTL_PARITY_MASK] &
			(TAP_STATE_I == `TAP_PAUSE_IR);
		2'b10: src_act = terminal;
		2'b11: src_act = cond_act;
		default: src_act = 1'b0;
		endcase
		level = src_act ? ctl[`CTL_OUT_HIGH] : ~ctl[`CTL_OUT_HIGH];
	end

	// Every pin output moves on the falling test clock edge
	always @(posedge CLK_I) begin
		if (clear) begin
			TDO_O <= 1'b1;
			TDO_OE_O <= 1'b0;
			CONDITION_OUTPUT_O <= 1'b1;
			CONDITION_OUTPUT_OE_O <= 1'b0;
			OPCODE_PARITY_FAULT_N_O <= 1'b1;
			TEST_MODE_O <= 1'b0;
		end else if (tck_fall) begin
			TDO_OE_O <= in_shift;
			TDO_O <= (TAP_STATE_I == `TAP_SHIFT_IR) ? ir_shift[0] : dr_lsb;
			OPCODE_PARITY_FAULT_N_O <= parity_n_q;
			TEST_MODE_O <= test_mode;
			if (test_mode) begin
				CONDITION_OUTPUT_O <= bsr_lat[`BSR_COND_OUT];
				CONDITION_OUTPUT_OE_O <= 1'b1;
			end else if (!ctl[`CTL_OUT_EN]) begin
				CONDITION_OUTPUT_O <= 1'b1;
				CONDITION_OUTPUT_OE_O <= 1'b0;
			end else if (ctl[`CTL_TRISTATE]) begin
				CONDITION_OUTPUT_O <= level;
				CONDITION_OUTPUT_OE_O <= 1'b1;
			end else begin
				// Open drain only pulls low; a high level is left to the pullup
				CONDITION_OUTPUT_O <= 1'b0;
				CONDITION_OUTPUT_OE_O <= ~level;
			end
		end
	end

	assign ACTIVE_OPCODE_O = ir_lat; // Straight from the shadow flops
	assign CONTROL_O = ctl;

endmodule

// file: tb/scan_linker_checker.sv
// Concurrent checks on the ports of the scan linker instruction decoder.
// Assumes the driver holds the TAP state for a whole test clock period.
`include "scan_linker_defs.vh"
module scan_linker_checker (
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic [3:0] TAP_STATE_I,
	input wire logic TDO_OE_O,
	input wire logic TEST_MODE_O,
	input wire logic OPCODE_PARITY_FAULT_N_O,
	input wire logic [7:0] ACTIVE_OPCODE_O,
	input wire logic [9:0] CONTROL_O,
	input wire logic [3:0] PATH_SELECT_O,
	input wire logic [7:0] COUNT_O
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RESETN_I);

	// Latches move only in their update state, or back to reset values
	chk_opcode_latch:
		assert property ($changed(ACTIVE_OPCODE_O) |-> TAP_STATE_I == `TAP_UPDATE_IR
			|| ACTIVE_OPCODE_O == `IR_RESET) else $error("opcode latch moved");
	chk_control_update:
		assert property ($changed(CONTROL_O) |-> TAP_STATE_I == `TAP_UPDATE_DR
			|| CONTROL_O == `CTL_RESET) else $error("control moved");
	chk_select_update:
		assert property ($changed(PATH_SELECT_O) |-> TAP_STATE_I == `TAP_UPDATE_DR
			|| PATH_SELECT_O == `PSEL_RESET) else $error("path select moved");
	// Parity flag agrees with the opcode it reports on whenever the flag changes
	chk_parity_flag:
		assert property ($changed(OPCODE_PARITY_FAULT_N_O)
			|-> OPCODE_PARITY_FAULT_N_O == ~^ACTIVE_OPCODE_O) else $error("parity flag wrong");
	chk_test_rise:
		assert property ($rose(TEST_MODE_O)
			|-> ACTIVE_OPCODE_O inside {`OP_EXTEST, `OP_INTEST}) else $error("test mode rose");
	chk_test_fall:
		assert property ($fell(TEST_MODE_O)
			|-> !(ACTIVE_OPCODE_O inside {`OP_EXTEST, `OP_INTEST})) else $error("test mode fell");
	// Serial out turns on only while a shift state is presented
	chk_tdo_enable:
		assert property ($rose(TDO_OE_O) |-> TAP_STATE_I inside {`TAP_SHIFT_DR, `TAP_SHIFT_IR})
			else $error("serial out enabled outside shift");
	// In idle the counter moves by one step under a count opcode; any move passes under the reset opcode
	chk_count_step:
		assert property ($changed(COUNT_O) && TAP_STATE_I == `TAP_RUN_TEST_IDLE
			|-> (ACTIVE_OPCODE_O inside {`OP_COUNT_A, `OP_COUNT_B}
			&& 8'(COUNT_O - $past(COUNT_O)) inside {8'h01, 8'hff})
			|| ACTIVE_OPCODE_O == `IR_RESET) else $error("counter step wrong");
	chk_reset_values:
		assert property ($rose(RESETN_I) |-> ACTIVE_OPCODE_O == `IR_RESET
			&& COUNT_O == `CNT_RESET && !TEST_MODE_O) else $error("reset values wrong");
endmodule

// file: tb/test_bus_ctrl.sv
// Model of the test bus controller: walks TAP states, drives test clock and data.
// Assumes the 200 MHz system clock; the test clock idles high between frames.
`include "scan_linker_defs.vh"
module test_bus_ctrl (
	input wire logic clk_i,
	input wire logic tdo_i,
	input wire logic [1:0] cond_i,
	output logic tck_o,
	output logic tdi_o,
	output logic [3:0] state_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] pause_seen;

	// ----------------------------------------------------------------
	// Frame tasks
	// ----------------------------------------------------------------
	initial begin
		tck_o = 1'b1;
		tdi_o = 1'b1;
		state_o = `TAP_TEST_LOGIC_RESET;
		pause_seen = 2'b00;
	end
	// One period; slow halves keep well clear of the synchroniser delay
	task automatic tick(input logic [3:0] st, input logic d, output logic q);
		state_o = st;
		tdi_o = d;
		tck_o = 1'b0;
		repeat (8) @(posedge clk_i);
		q = tdo_i; // Read before the rise, settled since the fall
		#1;
		tck_o = 1'b1;
		repeat (8) @(posedge clk_i);
		#1;
	endtask
	task automatic load_ir(input logic [7:0] op, input logic pz, output logic [7:0] status);
		logic q;
		tick(`TAP_CAPTURE_IR, 1'b1, q);
		for (int i = 0; i < 8; i++) begin
			tick(`TAP_SHIFT_IR, op[i], q); // Bit 0 first, parity last
			status[i] = q;
		end
		if (pz) begin
			tick(`TAP_PAUSE_IR, 1'b1, q);
			pause_seen = cond_i;
		end
		tick(`TAP_UPDATE_IR, 1'b1, q);
		tick(`TAP_RUN_TEST_IDLE, 1'b1, q);
	endtask
	task automatic scan_dr(input int n, input logic [15:0] din, output logic [15:0] dout);
		logic q;
		dout = 16'h0000;
		tick(`TAP_CAPTURE_DR, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			tick(`TAP_SHIFT_DR, din[i], q); // LSB first
			dout[i] = q;
		end
		tick(`TAP_UPDATE_DR, 1'b1, q);
		tick(`TAP_RUN_TEST_IDLE, 1'b1, q);
	endtask
endmodule

// file: tb/tb_scan_linker_instruction_decode.sv
// Self-checking bench for the scan linker instruction decoder.
// Assumes the controller model for all test clock traffic.
`include "scan_linker_defs.vh"
module tb_scan_linker_instruction_decode;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic [7:0] op; int len; logic tm;} row_t;
	logic clk, reset_n, trst_n, cond_in, pn_prev, tck, tdi, tdo, tdo_oe, co, co_oe, pfn, tm;
	logic use_sec, sec_in;
	logic [3:0] state, id_bus, psel;
	logic [7:0] st, opc, cnt;
	logic [9:0] ctl, ctl_exp;
	logic [15:0] dout;
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	// Length of the register each opcode puts between serial in and out
	row_t rows[16] = '{'{8'h00, 6, 1}, '{8'h03, 6, 1}, '{8'h82, 6, 0}, '{8'h81, 1, 0},
		'{8'h84, 1, 0}, '{8'h01, 1, 0}, '{8'h88, 1, 0}, '{8'h09, 1, 0}, '{8'h8e, 10, 0},
		'{8'h0f, 10, 0}, '{8'hfa, 8, 0}, '{8'h7b, 8, 0}, '{8'hfc, 4, 0}, '{8'h7d, 4, 0},
		'{8'h7e, 4, 0}, '{8'h55, 1, 0}};

	scan_linker_instruction_decode dut (.CLK_I(clk), .RESETN_I(reset_n), .TCK_I(tck),
		.TRST_N_I(trst_n), .TDI_I(tdi), .SECONDARY_SERIAL_IN_I(sec_in), .USE_SECONDARY_I(use_sec),
		.TAP_STATE_I(state), .CONDITION_INPUT_I(cond_in), .ID_BUS_I(id_bus), .TDO_O(tdo),
		.TDO_OE_O(tdo_oe), .CONDITION_OUTPUT_O(co), .CONDITION_OUTPUT_OE_O(co_oe),
		.OPCODE_PARITY_FAULT_N_O(pfn), .TEST_MODE_O(tm), .ACTIVE_OPCODE_O(opc),
		.CONTROL_O(ctl), .PATH_SELECT_O(psel), .COUNT_O(cnt));
	test_bus_ctrl tbc (.clk_i(clk), .tdo_i(tdo), .cond_i({co_oe, co}), .tck_o(tck),
		.tdi_o(tdi), .state_o(state));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// A hang is cut short well past the expected run of some 12000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check_reset();
		check(opc, `IR_RESET);
		check({ctl, psel}, 14'h0000);
		check({cnt, pfn, tm, tdo_oe}, 11'h004);
	endtask
	task automatic set_ctl(input logic [9:0] v);
		tbc.load_ir(`OP_CTL_SCAN_A, 1'b0, st);
		tbc.scan_dr(10, {6'h00, v}, dout);
		ctl_exp = v;
	endtask
	// Each pulse gives one rising and one falling condition edge
	task automatic pulses(input int n);
		repeat (n) begin
			cond_in = ~cond_in;
			step(8);
			cond_in = ~cond_in;
			step(8);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		trst_n = 1'b1;
		cond_in = 1'b0;
		use_sec = 1'b0;
		sec_in = 1'b0;
		id_bus = 4'h9;
		ctl_exp = 10'h000;
		pn_prev = 1'b1;
		step(8);
		reset_n = 1'b1;
		step(4);
		check_reset();
		$display("reset test done");
		for (int r = 0; r < 16; r++) begin
			tbc.load_ir(rows[r].op, 1'b0, st);
			check(st, {pn_prev, 3'b000, ~(cond_in ^ ctl_exp[1]), 3'b001});
			pn_prev = ~^rows[r].op;
			check(opc, rows[r].op);
			check(pfn, pn_prev);
			check(tm, rows[r].tm);
			// Test mode drives the last loaded boundary output cell onto the pin
			if (rows[r].tm)
				check({co_oe, co}, {1'b1, r[0]});
			tbc.scan_dr(16, 16'ha5c3, dout);
			if (rows[r].len == 6)
				check(dout[3:0], id_bus);
			check(dout >> rows[r].len, 16'ha5c3 & (16'hffff >> rows[r].len));
			if (rows[r].len == 1)
				check(dout[0], 1'b0);
			if (rows[r].len == 10)
				ctl_exp = 10'h297;
			check(ctl, ctl_exp);
			$display("row %0d opcode %h done", r, rows[r].op);
		end
		check(psel, 4'ha);
		// Counter: preload, count, live and prior-preload reads
		set_ctl(10'h002);
		tbc.load_ir(`OP_COUNTER_SCAN, 1'b0, st);
		tbc.scan_dr(8, 16'h00f0, dout);
		check(cnt, 8'hf0);
		tbc.load_ir(`OP_COUNT_A, 1'b0, st);
		pulses(3);
		check(cnt, 8'hf3);
		tbc.load_ir(`OP_COUNTER_SCAN, 1'b0, st);
		tbc.scan_dr(8, 16'h0020, dout);
		check(dout, 16'h00f3);
		tbc.load_ir(`OP_COUNT_A, 1'b0, st);
		pulses(2);
		tbc.load_ir(`OP_COUNTER_READ, 1'b0, st);
		tbc.scan_dr(8, 16'h0055, dout);
		check({dout[7:0], cnt}, 16'h2055);
		set_ctl(10'h200);
		tbc.load_ir(`OP_COUNT_B, 1'b0, st);
		pulses(2);
		check(cnt, 8'h53);
		$display("counter test done");
		// Identification bus and boundary sampling
		tbc.load_ir(`OP_ID_BUS_SCAN, 1'b0, st);
		tbc.scan_dr(4, 16'h0000, dout);
		check(dout, 16'h0009);
		id_bus = 4'h6;
		tbc.load_ir(`OP_SAMPLE, 1'b0, st);
		tbc.scan_dr(6, 16'h0000, dout);
		check(dout[4:0], {cond_in, 4'h6});
		$display("capture test done");
		// Parity fault shown on the condition output in Pause-IR
		set_ctl(10'h02c);
		tbc.load_ir(8'h01, 1'b0, st);
		tbc.load_ir(`OP_BYPASS, 1'b1, st);
		check(tbc.pause_seen, 2'b10);
		tbc.load_ir(`OP_BYPASS, 1'b1, st);
		check(tbc.pause_seen, 2'b11);
		$display("pause test done");
		// Data registers take the secondary serial input when it is chosen
		use_sec = 1'b1;
		tbc.scan_dr(4, 16'h000f, dout);
		check(dout, 16'h0000);
		use_sec = 1'b0;
		$display("secondary path test done");
		// Test reset in mid-run
		trst_n = 1'b0;
		step(6);
		trst_n = 1'b1;
		step(6);
		check_reset();
		$display("test reset done");
		tally_and_finish();
	end
endmodule

bind scan_linker_instruction_decode scan_linker_checker chk (.CLK_I(CLK_I),
	.RESETN_I(RESETN_I), .TAP_STATE_I(TAP_STATE_I), .TDO_OE_O(TDO_OE_O),
	.TEST_MODE_O(TEST_MODE_O), .OPCODE_PARITY_FAULT_N_O(OPCODE_PARITY_FAULT_N_O),
	.ACTIVE_OPCODE_O(ACTIVE_OPCODE_O), .CONTROL_O(CONTROL_O),
	.PATH_SELECT_O(PATH_SELECT_O), .COUNT_O(COUNT_O));
